// >>> design/dual_uart_pkg.sv
// shared constants and types for the dual serial port control block
`default_nettype none
package dual_uart_pkg;
// Contract
// - completion flags of both ports stay set until software clears them
// - multiprocessor enable raises receive events only for nine-bit frames with ninth bit set, or eight-bit frames with a valid stop bit
// - reception happens only while the receive enable bit is set
// - port zero nine-bit modes send the software-written ninth bit
// - port zero captures ninth received bit, or stop bit in mode 01 unfiltered
// - transmit and receive flags set at frame end and held until cleared
// - port one mode bit 0 gives nine-bit frame, 1 gives eight-bit frame
// - port one nine-bit mode sends the software-written ninth bit
// - port one captures ninth received bit, or stop bit in eight-bit unfiltered
// - power control top bit doubles the baud rate of port zero only
// - stop bit halts flash access and both ports until an external interrupt
// - idle bit halts flash access only until an internal interrupt
// - frames go least significant bit first between start and stop bits
// - port zero mode 10 runs at clock over 64, or over 32 when doubled
// - writing a transmit buffer starts sending; receive buffer holds received byte
  localparam logic [7:0] IDX_POWER = 8'h87;
  localparam logic [7:0] IDX_PORT0_CTRL = 8'h98;
  localparam logic [7:0] IDX_PORT1_CTRL = 8'h9b;
  localparam logic [7:0] IDX_TX_BUF0 = 8'ha0;
  localparam logic [7:0] IDX_RX_BUF0 = 8'ha1;
  localparam logic [7:0] IDX_TX_BUF1 = 8'ha2;
  localparam logic [7:0] IDX_RX_BUF1 = 8'ha3;
  localparam logic [7:0] IDX_RELOAD0 = 8'ha4;
  localparam logic [7:0] IDX_RELOAD1 = 8'ha5;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'ha6;
  localparam logic [7:0] IDX_IRQ_MASK = 8'ha7;
  localparam int unsigned CTL_MODE_HI = 7;
  localparam int unsigned CTL_MODE_LO = 6;
  localparam int unsigned CTL_MP_EN = 5;
  localparam int unsigned CTL_RX_EN = 4;
  localparam int unsigned CTL_TX_NINTH = 3;
  localparam int unsigned CTL_RX_NINTH = 2;
  localparam int unsigned CTL_TX_DONE = 1;
  localparam int unsigned CTL_RX_DONE = 0;
  localparam int unsigned PWR_DOUBLE = 7;
  localparam int unsigned PWR_STOP = 1;
  localparam int unsigned PWR_IDLE = 0;
  localparam logic [7:0] PWR_WMASK = 8'h83;
  localparam logic [7:0] CTL1_WMASK = 8'hbf;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] POWER_RESET = 8'h00;
  localparam logic [15:0] RELOAD_RESET = 16'h0043;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [15:0] FIXED_DIV_NORMAL = 16'h0004;
  localparam logic [15:0] FIXED_DIV_DOUBLE = 16'h0002;
  localparam logic [3:0] BITS_EIGHT = 4'ha;
  localparam logic [3:0] BITS_NINE = 4'hb;
  localparam int unsigned IRQ_W = 4;
  typedef struct packed {
    logic enable;
    logic nine_bit;
    logic tx_ninth;
    logic mp_en;
    logic rx_en;
  } port_cfg_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] idx;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;
endpackage : dual_uart_pkg
`default_nettype wire

// >>> design/dual_uart_serial_control.sv
// two serial ports with control, power and interrupt registers on classic wishbone
//
// The Wishbone interface to the registers was decided locally.
`default_nettype none
module dual_uart_serial_control
  import dual_uart_pkg::*;
#(
  parameter int unsigned DIV_W = 16
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic rxd0_i,
  input wire logic rxd1_i,
  output logic txd0_o,
  output logic txd1_o,
  input wire logic ext_irq_i,
  input wire logic int_irq_i,
  output logic irq_o,
  output logic flash_halt_o,
  output logic periph_halt_o
);
  // the reload high byte starts at bit 8, so narrower widths cannot be served
  if (DIV_W < 9 || DIV_W > 16) begin : g_bad_div
    $error("DIV_W must lie between 9 and 16");
  end

  wb_req_t req;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [7:0] power_ff;
  logic [7:0] ctl_ff [2];
  logic [7:0] rxbuf_ff [2];
  logic [DIV_W-1:0] reload_ff [2];
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic irq_ff;
  logic flash_halt_ff;
  logic periph_halt_ff;
  logic [1:0] wake_sync_ff;
  logic wr_acc;
  port_cfg_t cfg [2];
  logic [DIV_W-1:0] limit [2];
  logic tick [2];
  logic tx_start [2];
  logic tx_evt [2];
  logic tx_busy [2];
  logic rx_evt [2];
  logic rx_ninth_val [2];
  logic [7:0] rx_data_val [2];
  logic [1:0] rxd_pin;
  logic txd_ff [2];
  logic [9:0] tx_shift_dbg [2];
  logic [3:0] tx_bits_dbg [2];

  assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, idx: adr_i[9:2], sel: sel_i, dat: dat_i};
  // writes land on the edge where the master sees ack, matching its view
  assign wr_acc = req.cyc && req.stb && req.we && ack_ff;
  assign rxd_pin = {rxd1_i, rxd0_i};
  assign ack_o = ack_ff;
  assign dat_o = dat_ff;
  assign irq_o = irq_ff;
  assign txd0_o = txd_ff[0];
  assign txd1_o = txd_ff[1];
  assign flash_halt_o = flash_halt_ff;
  assign periph_halt_o = periph_halt_ff;

  always_comb
  begin
    cfg[0].enable = ctl_ff[0][CTL_MODE_HI] | ctl_ff[0][CTL_MODE_LO];
    cfg[0].nine_bit = ctl_ff[0][CTL_MODE_HI];
    cfg[1].enable = 1'b1;
    cfg[1].nine_bit = ~ctl_ff[1][CTL_MODE_HI];
    for (int p = 0; p < 2; p++)
    begin
      cfg[p].tx_ninth = ctl_ff[p][CTL_TX_NINTH];
      cfg[p].mp_en = ctl_ff[p][CTL_MP_EN];
      cfg[p].rx_en = ctl_ff[p][CTL_RX_EN];
    end
    // port one has no doubling; its rate comes only from its reload
    if (ctl_ff[0][CTL_MODE_HI] && !ctl_ff[0][CTL_MODE_LO])
      limit[0] = power_ff[PWR_DOUBLE] ? FIXED_DIV_DOUBLE[DIV_W-1:0] : FIXED_DIV_NORMAL[DIV_W-1:0];
    else
      limit[0] = power_ff[PWR_DOUBLE] ? (reload_ff[0] >> 1) : reload_ff[0];
    limit[1] = reload_ff[1];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= req.cyc && req.stb && !ack_ff;
      dat_ff <= 32'h0000_0000;
      if (req.idx == IDX_POWER)
        dat_ff[7:0] <= power_ff & PWR_WMASK;
      else if (req.idx == IDX_PORT0_CTRL)
        dat_ff[7:0] <= ctl_ff[0];
      else if (req.idx == IDX_PORT1_CTRL)
        dat_ff[7:0] <= ctl_ff[1] & CTL1_WMASK;
      else if (req.idx == IDX_RX_BUF0)
        dat_ff[7:0] <= rxbuf_ff[0];
      else if (req.idx == IDX_RX_BUF1)
        dat_ff[7:0] <= rxbuf_ff[1];
      else if (req.idx == IDX_RELOAD0)
        dat_ff[DIV_W-1:0] <= reload_ff[0];
      else if (req.idx == IDX_RELOAD1)
        dat_ff[DIV_W-1:0] <= reload_ff[1];
      else if (req.idx == IDX_IRQ_STATUS)
        dat_ff[IRQ_W-1:0] <= irq_stat_ff;
      else if (req.idx == IDX_IRQ_MASK)
        dat_ff[IRQ_W-1:0] <= irq_mask_ff;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wake_sync_ff <= 2'b00;
      power_ff <= POWER_RESET;
      flash_halt_ff <= 1'b0;
      periph_halt_ff <= 1'b0;
    end
    else
    begin
      wake_sync_ff <= {wake_sync_ff[0], ext_irq_i};
      if (wr_acc && req.idx == IDX_POWER && req.sel[0])
        power_ff <= req.dat[7:0] & PWR_WMASK;
      if (wake_sync_ff[1])
        power_ff[PWR_STOP] <= 1'b0;
      if (int_irq_i)
        power_ff[PWR_IDLE] <= 1'b0;
      flash_halt_ff <= power_ff[PWR_STOP] | power_ff[PWR_IDLE];
      periph_halt_ff <= power_ff[PWR_STOP];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctl_ff[0] <= CTRL_RESET;
      ctl_ff[1] <= CTRL_RESET;
      rxbuf_ff[0] <= 8'h00;
      rxbuf_ff[1] <= 8'h00;
      reload_ff[0] <= RELOAD_RESET[DIV_W-1:0];
      reload_ff[1] <= RELOAD_RESET[DIV_W-1:0];
    end
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        if (wr_acc && req.sel[0] && req.idx == (p == 0 ? IDX_PORT0_CTRL : IDX_PORT1_CTRL))
          ctl_ff[p] <= req.dat[7:0] & (p == 0 ? 8'hff : CTL1_WMASK);
        if (wr_acc && req.idx == (p == 0 ? IDX_RELOAD0 : IDX_RELOAD1))
        begin
          if (req.sel[0])
            reload_ff[p][7:0] <= req.dat[7:0];
          if (req.sel[1])
            reload_ff[p][DIV_W-1:8] <= req.dat[DIV_W-1:8];
        end
        // hardware set wins over a same-cycle software clear
        if (tx_evt[p])
          ctl_ff[p][CTL_TX_DONE] <= 1'b1;
        if (rx_evt[p])
        begin
          ctl_ff[p][CTL_RX_DONE] <= 1'b1;
          ctl_ff[p][CTL_RX_NINTH] <= rx_ninth_val[p];
          rxbuf_ff[p] <= rx_data_val[p];
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_ff <= 1'b0;
    end
    else
    begin
      if (wr_acc && req.sel[0] && req.idx == IDX_IRQ_MASK)
        irq_mask_ff <= req.dat[IRQ_W-1:0];
      irq_stat_ff <= (irq_stat_ff & ~((wr_acc && req.sel[0] && req.idx == IDX_IRQ_STATUS) ?
        req.dat[IRQ_W-1:0] : '0)) | {rx_evt[1], tx_evt[1], rx_evt[0], tx_evt[0]};
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [DIV_W-1:0] div_cnt_ff;
    logic [10:0] tx_shift_ff;
    logic [3:0] tx_bits_ff;
    logic [3:0] tx_os_ff;
    logic tx_busy_ff;
    logic [2:0] rx_sync_ff;
    logic rx_busy_ff;
    logic [3:0] rx_os_ff;
    logic [3:0] rx_cnt_ff;
    logic [9:0] rx_shift_ff;
    logic rx_evt_ff;
    logic [3:0] rx_need;

    assign tx_start[p] = wr_acc && req.sel[0] && req.idx == (p == 0 ? IDX_TX_BUF0 : IDX_TX_BUF1)
      && cfg[p].enable && !tx_busy_ff && !power_ff[PWR_STOP];
    assign tx_busy[p] = tx_busy_ff;
    assign tx_shift_dbg[p] = tx_shift_ff[9:0];
    assign tx_bits_dbg[p] = tx_bits_ff;
    assign rx_need = cfg[p].nine_bit ? 4'ha : 4'h9;
    assign rx_evt[p] = rx_evt_ff;

    // the stop bit freezes the divider, which halts both engines mid-frame
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        div_cnt_ff <= '0;
      else if (!power_ff[PWR_STOP])
        div_cnt_ff <= (div_cnt_ff + 1'b1 >= limit[p]) ? '0 : div_cnt_ff + 1'b1;
    end
    assign tick[p] = !power_ff[PWR_STOP] && (div_cnt_ff + 1'b1 >= limit[p]);

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        tx_busy_ff <= 1'b0;
        tx_shift_ff <= '1;
        tx_bits_ff <= 4'h0;
        tx_os_ff <= 4'h0;
        txd_ff[p] <= 1'b1;
        tx_evt[p] <= 1'b0;
      end
      else
      begin
        tx_evt[p] <= 1'b0;
        if (tx_start[p])
        begin
          tx_busy_ff <= 1'b1;
          tx_os_ff <= 4'h0;
          txd_ff[p] <= 1'b0;
          if (cfg[p].nine_bit)
          begin
            tx_shift_ff <= {1'b1, cfg[p].tx_ninth, req.dat[7:0], 1'b0};
            tx_bits_ff <= BITS_NINE;
          end
          else
          begin
            tx_shift_ff <= {2'b11, req.dat[7:0], 1'b0};
            tx_bits_ff <= BITS_EIGHT;
          end
        end
        else if (tx_busy_ff && tick[p])
        begin
          tx_os_ff <= tx_os_ff + 1'b1;
          if (tx_os_ff == OS_LAST)
          begin
            if (tx_bits_ff == 4'h1)
            begin
              tx_busy_ff <= 1'b0;
              tx_evt[p] <= 1'b1;
              txd_ff[p] <= 1'b1;
            end
            else
            begin
              tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
              txd_ff[p] <= tx_shift_ff[1];
              tx_bits_ff <= tx_bits_ff - 1'b1;
            end
          end
        end
      end
    end

    always_comb
    begin
      rx_data_val[p] = cfg[p].nine_bit ? rx_shift_ff[7:0] : rx_shift_ff[8:1];
      // eight-bit frames put the stop bit where the ninth bit would be
      rx_ninth_val[p] = cfg[p].nine_bit ? rx_shift_ff[8] : rx_shift_ff[9];
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        rx_sync_ff <= 3'b111;
        rx_busy_ff <= 1'b0;
        rx_os_ff <= 4'h0;
        rx_cnt_ff <= 4'h0;
        rx_shift_ff <= '0;
        rx_evt_ff <= 1'b0;
      end
      else
      begin
        rx_sync_ff <= {rx_sync_ff[1:0], rxd_pin[p]};
        rx_evt_ff <= 1'b0;
        if (!rx_busy_ff)
        begin
          if (rx_sync_ff[2] && !rx_sync_ff[1] && cfg[p].rx_en && cfg[p].enable && !power_ff[PWR_STOP])
          begin
            rx_busy_ff <= 1'b1;
            rx_os_ff <= 4'h0;
            rx_cnt_ff <= 4'h0;
          end
        end
        else if (!cfg[p].rx_en)
          rx_busy_ff <= 1'b0;
        else if (tick[p])
        begin
          rx_os_ff <= rx_os_ff + 1'b1;
          if (rx_os_ff == OS_MID)
          begin
            rx_cnt_ff <= rx_cnt_ff + 1'b1;
            if (rx_cnt_ff == 4'h0)
            begin
              if (rx_sync_ff[2])
                rx_busy_ff <= 1'b0;
            end
            else
              rx_shift_ff <= {rx_sync_ff[2], rx_shift_ff[9:1]};
            if (rx_cnt_ff == rx_need)
            begin
              rx_busy_ff <= 1'b0;
              // filtering: nine-bit needs ninth set, eight-bit needs a valid stop
              // the ninth bit sits at the top of the shifter before the stop is taken
              rx_evt_ff <= !cfg[p].mp_en || (cfg[p].nine_bit ? rx_shift_ff[9] : rx_sync_ff[2]);
            end
          end
        end
      end
    end
  end

  AST_FLAG_HELD: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl_ff[0][CTL_TX_DONE] && !(wr_acc && req.idx == IDX_PORT0_CTRL) |=> ctl_ff[0][CTL_TX_DONE])
    else $error("port zero transmit flag dropped without a write");
  AST_MODE00_NO_TX: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctl_ff[0][CTL_MODE_HI] && !ctl_ff[0][CTL_MODE_LO] && !tx_busy[0] |=> !tx_busy[0])
    else $error("port zero sent in unsupported mode");
  AST_MP_FILTER: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_evt[1] && cfg[1].nine_bit && cfg[1].mp_en |-> rx_ninth_val[1])
    else $error("filtered frame without ninth bit raised an event");
  AST_RX_ENABLE: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_evt[0] |-> $past(cfg[0].rx_en))
    else $error("frame received while reception disabled");
  AST_TX_NINTH: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_start[0] && cfg[0].nine_bit |=> tx_shift_dbg[0][9] == $past(cfg[0].tx_ninth) && tx_bits_dbg[0] == 4'hb)
    else $error("ninth transmit bit not loaded");
  AST_RX_NINTH: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_evt[0] |=> ctl_ff[0][CTL_RX_NINTH] == $past(rx_ninth_val[0]) && ctl_ff[0][CTL_RX_DONE])
    else $error("ninth receive bit not captured");
  AST_TX_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_evt[1] |=> ctl_ff[1][CTL_TX_DONE] ##1 irq_stat_ff[2])
    else $error("port one transmit completion not recorded");
  AST_P1_EIGHT: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_start[1] && ctl_ff[1][CTL_MODE_HI] |=> tx_bits_dbg[1] == 4'ha && !txd_ff[1])
    else $error("port one eight-bit frame length wrong");
  AST_DOUBLE: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl_ff[0][CTL_MODE_LO] && power_ff[PWR_DOUBLE] |-> limit[0] == (reload_ff[0] >> 1))
    else $error("doubling did not halve the divisor");
  AST_STOP_HALT: assert property (@(posedge clk_i) disable iff (rst_i)
    power_ff[PWR_STOP] |-> !tick[0] && !tick[1] ##1 periph_halt_o && flash_halt_o)
    else $error("ports ran during stop");
  AST_FIXED_RATE: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl_ff[0][7:6] == 2'b10 && !power_ff[PWR_DOUBLE] |-> limit[0] == 16'h0004)
    else $error("fixed rate divisor wrong");
  AST_PWR_UNUSED: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_acc && req.idx == IDX_POWER |=> power_ff[6:2] == 5'h00)
    else $error("unused power bits took a write");
  COV_TX0: cover property (@(posedge clk_i) disable iff (rst_i) tx_evt[0]);
  COV_RX1: cover property (@(posedge clk_i) disable iff (rst_i) rx_evt[1]);
  COV_IRQ: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
  COV_WAKE: cover property (@(posedge clk_i) disable iff (rst_i) $fell(periph_halt_o));
endmodule : dual_uart_serial_control
`default_nettype wire

// >>> tb/serial_peer.sv
// behavioural far-side serial device: drives frames into a port, captures frames from it
`default_nettype none
module serial_peer
(
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle mark between frames, the line's resting level
  initial rxd_o = 1'b1;
  task automatic send(input logic [8:0] d, input int nb, input int per);
    logic [10:0] f;
    f = (nb == 9) ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
    for (int i = 0; i < nb + 2; i++)
    begin
      @(posedge clk_i);
      rxd_o <= f[i];
      repeat (per - 1) @(posedge clk_i);
    end
  endtask : send
  task automatic recv(output logic [8:0] d, output logic stop, input int nb, input int per);
    int n;
    n = 0;
    d = 9'h000;
    while (txd_i !== 1'b0 && n < 4000)
    begin
      @(posedge clk_i);
      n++;
    end
    // sample each bit near its middle
    repeat (per / 2) @(posedge clk_i);
    for (int i = 0; i < nb; i++)
    begin
      repeat (per) @(posedge clk_i);
      d[i] = txd_i;
    end
    repeat (per) @(posedge clk_i);
    stop = txd_i;
  endtask : recv
endmodule : serial_peer
`default_nettype wire

// >>> tb/tb_dual_uart_serial_control.sv
// register-level bench for the dual serial port control block
`default_nettype none
module tb_dual_uart_serial_control;
  import dual_uart_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, cyc, stb, we, ack, rxd0, rxd1, txd0, txd1;
  logic ext_irq, int_irq, irq, flash_halt, periph_halt;
  logic [31:0] adr, dat_w, dat_r, lows;
  logic [3:0] sel;
  logic [8:0] got;
  int n_fail = 0;
  int cmp_count = 0;
  dual_uart_serial_control dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .rxd0_i(rxd0), .rxd1_i(rxd1),
    .txd0_o(txd0), .txd1_o(txd1), .ext_irq_i(ext_irq), .int_irq_i(int_irq), .irq_o(irq),
    .flash_halt_o(flash_halt), .periph_halt_o(periph_halt));
  serial_peer peer0 (.clk_i(clk_i), .txd_i(txd0), .rxd_o(rxd0));
  serial_peer peer1 (.clk_i(clk_i), .txd_i(txd1), .rxd_o(rxd1));
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic tally_and_finish();
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {22'h0, idx, 2'b00};
    dat_w <= wd;
    // look at ack mid-cycle, then release only after the edge that sees it high
    do
    begin
      @(negedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    rd = dat_r;
    @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 100)
    begin
      n_fail++;
      tally_and_finish();
    end
  endtask : wb
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, idx, d, x);
  endtask : wr
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    wb(1'b0, idx, 32'h0, v);
    chk(v, exp);
  endtask : rdchk
  // bounded like software's character timeout, so a lost flag cannot hang the run
  task automatic poll_tx(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    for (int i = 0; i < 200; i++)
    begin
      wb(1'b0, idx, 32'h0, v);
      if (v[1] === 1'b1)
        break;
    end
    chk(v, exp);
  endtask : poll_tx
  task automatic tx_case(input int p, input logic [7:0] d, input int nb, input int per, output logic [8:0] g);
    logic st;
    fork
      if (p == 0) peer0.recv(g, st, nb, per); else peer1.recv(g, st, nb, per);
      wr(p == 0 ? IDX_TX_BUF0 : IDX_TX_BUF1, {24'h0, d});
    join
    chk({31'h0, st}, 32'h1);
  endtask : tx_case
  task automatic rx_send(input int p, input logic [8:0] d, input int nb, input int per);
    if (p == 0) peer0.send(d, nb, per); else peer1.send(d, nb, per);
    repeat (4) @(posedge clk_i);
  endtask : rx_send
  task automatic pulse(input int which);
    if (which == 0) ext_irq <= 1'b1; else int_irq <= 1'b1;
    repeat (4) @(posedge clk_i);
    ext_irq <= 1'b0;
    int_irq <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : pulse
  initial
  begin
    rst_i = 1'b1;
    {cyc, stb, we, ext_irq, int_irq} = 5'h00;
    adr = 32'h0;
    dat_w = 32'h0;
    sel = 4'hf;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(IDX_POWER, 32'h0);
    rdchk(IDX_PORT0_CTRL, 32'h0);
    rdchk(IDX_PORT1_CTRL, 32'h0);
    wr(IDX_POWER, 32'h7c);
    rdchk(IDX_POWER, 32'h0);
    wr(8'h10, 32'hff);
    rdchk(8'h10, 32'h0);
    wr(IDX_TX_BUF0, 32'h55);
    lows = 32'h0;
    repeat (200) @(posedge clk_i) if (txd0 !== 1'b1) lows++;
    chk(lows, 32'h0);
    rdchk(IDX_PORT0_CTRL, 32'h0);
    wr(IDX_RELOAD1, 32'h1);
    wr(IDX_PORT1_CTRL, 32'h08);
    tx_case(1, 8'ha5, 9, 16, got);
    chk({23'h0, got}, 32'h1a5);
    poll_tx(IDX_PORT1_CTRL, 32'h0a);
    rdchk(IDX_IRQ_STATUS, 32'h4);
    wr(IDX_IRQ_MASK, 32'h4);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_MASK, 32'h0);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_MASK, 32'h4);
    wr(IDX_IRQ_STATUS, 32'h4);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    rdchk(IDX_IRQ_STATUS, 32'h0);
    rdchk(IDX_PORT1_CTRL, 32'h0a);
    wr(IDX_PORT1_CTRL, 32'h80);
    rx_send(1, 9'h03c, 8, 16);
    rdchk(IDX_PORT1_CTRL, 32'h80);
    wr(IDX_PORT1_CTRL, 32'h90);
    rx_send(1, 9'h03c, 8, 16);
    rdchk(IDX_PORT1_CTRL, 32'h95);
    rdchk(IDX_RX_BUF1, 32'h3c);
    tx_case(1, 8'hc3, 8, 16, got);
    chk({23'h0, got}, 32'h0c3);
    poll_tx(IDX_PORT1_CTRL, 32'h97);
    wr(IDX_PORT1_CTRL, 32'h30);
    rx_send(1, 9'h011, 9, 16);
    rdchk(IDX_PORT1_CTRL, 32'h30);
    rx_send(1, 9'h122, 9, 16);
    rdchk(IDX_PORT1_CTRL, 32'h35);
    rdchk(IDX_RX_BUF1, 32'h22);
    // reload 2 halved by doubling gives a 16-clock bit
    wr(IDX_RELOAD0, 32'h2);
    wr(IDX_POWER, 32'h80);
    wr(IDX_PORT0_CTRL, 32'h40);
    tx_case(0, 8'h5a, 8, 16, got);
    chk({23'h0, got}, 32'h05a);
    // let the stop bit finish at the old rate before the rate changes
    poll_tx(IDX_PORT0_CTRL, 32'h42);
    wr(IDX_POWER, 32'h00);
    wr(IDX_PORT0_CTRL, 32'h88);
    tx_case(0, 8'hc3, 9, 64, got);
    chk({23'h0, got}, 32'h1c3);
    poll_tx(IDX_PORT0_CTRL, 32'h8a);
    wr(IDX_POWER, 32'h80);
    for (int k = 0; k < 2; k++)
    begin
      wr(IDX_PORT0_CTRL, 32'hd0);
      rx_send(0, {k[0], 8'ha6}, 9, 16);
      rdchk(IDX_PORT0_CTRL, k == 0 ? 32'hd1 : 32'hd5);
      rdchk(IDX_RX_BUF0, 32'ha6);
    end
    wr(IDX_POWER, 32'h02);
    repeat (3) @(posedge clk_i);
    chk({30'h0, flash_halt, periph_halt}, 32'h3);
    pulse(0);
    chk({30'h0, flash_halt, periph_halt}, 32'h0);
    rdchk(IDX_POWER, 32'h0);
    wr(IDX_POWER, 32'h01);
    repeat (3) @(posedge clk_i);
    chk({30'h0, flash_halt, periph_halt}, 32'h2);
    pulse(1);
    chk({30'h0, flash_halt, periph_halt}, 32'h0);
    tally_and_finish();
  end
  initial
  begin
    repeat (50000) @(posedge clk_i);
    n_fail++;
    tally_and_finish();
  end
endmodule : tb_dual_uart_serial_control
`default_nettype wire
